// ===== adc_model.sv
// Converter model: free-running strobe, one word per channel per sample.
// Assumes a 100 MHz clock; words change well clear of the strobe rise.
`timescale 1ns/1ps

module adc_model
  import ppx_pkg::*;
(
  // Clock and reset
  input wire logic                              clk,
  input wire logic                              rst,
  // Analogue levels as seen by the converters
  input wire logic [NUM_CHAN-1:0][SAMPLE_W-1:0] level,
  // Converter outputs
  output logic                                  sampleStrobe,
  output logic [NUM_CHAN-1:0][SAMPLE_W-1:0]     sampleData
);
  logic [3:0] phase;

  // 10 clocks per sample gives the 10 MHz rate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= 4'h0;
    end else begin
      phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sampleStrobe <= 1'b0;
    end else begin
      sampleStrobe <= (phase < 4'h5);
    end
  end

  // Words settle 3 clocks before the rise, all channels at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sampleData <= '0;
    end else if (phase == 4'h7) begin
      sampleData <= level;
    end
  end
endmodule : adc_model

// ===== ppx_pkg.sv
// Package for the pulse parameter extractor: widths, register map,
// reset values and the event record.
// Assumes a 100 MHz system clock and converter samples near 10 MHz.
package ppx_pkg;

  // Data path sizes
  localparam int NUM_CHAN   = 16;
  localparam int SAMPLE_W   = 14;
  localparam int PARAM_W    = 18;
  localparam int SUM_W      = 32;
  localparam int TIME_W     = 32;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int SEL_W      = 6;

  // Scaling figures
  localparam int HEIGHT_SHIFT = 4;   // Times 16
  localparam int WIDTH_SHIFT  = 16;  // Times 64K
  localparam int AREA_FRAC    = 8;   // Area scale is 8.8 fixed point
  localparam int RATIO_FRAC   = 8;
  localparam logic [PARAM_W-1:0] PARAM_MAX = 18'h3ffff;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CHAN_EN   = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_WIN_EXT   = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_AREA_SCL  = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_RATIO_SEL = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_ABORTS    = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_EVENTS    = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_IGNORED   = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_THR_BASE  = 8'h40;

  // Control fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_AND    = 1;
  localparam int CTRL_PURITY = 2;

  // Reset values
  localparam logic [2:0]          CTRL_RST      = 3'h0;
  localparam logic [15:0]         CHAN_EN_RST   = 16'h0001;
  localparam logic [15:0]         WIN_EXT_RST   = 16'h0000;
  localparam logic [15:0]         AREA_SCL_RST  = 16'h0100;
  localparam logic [SAMPLE_W-1:0] THR_RST       = 14'h0100;
  localparam logic [2*SEL_W-1:0]  RATIO_SEL_RST = 12'h000;

  typedef struct packed {
    logic [PARAM_W-1:0] area;
    logic [PARAM_W-1:0] height;
    logic [PARAM_W-1:0] width;
  } chan_param_t;

  typedef struct packed {
    chan_param_t [NUM_CHAN-1:0] chan;
    logic [TIME_W-1:0]          timeStamp;
    logic [PARAM_W-1:0]         ratio;
  } event_t;

  typedef enum logic [1:0] { ST_IDLE, ST_OPEN, ST_EXTEND } win_state_t;

endpackage : ppx_pkg

// ===== ppx_props.sv
// Checker for the pulse parameter extractor, ports only.
// Assumes clkEn held high and one converter sample per 10 clocks.
`timescale 1ns/1ps

module ppx_props
  import ppx_pkg::*;
(
  // Clock and reset
  input wire logic                clk,
  input wire logic                rst,
  // Converter side
  input wire logic                sampleStrobe,
  // Register port
  input wire logic [ADDR_W-1:0]   regAddr,
  input wire logic                regRd,
  input wire logic [DATA_W-1:0]   regRdData,
  // Event output
  input wire logic                evtValid,
  input wire logic                evtReady,
  input wire event_t              evtData
);
  logic [3:0]        sinceRise;
  logic [TIME_W-1:0] lastTs;
  logic              seenOne;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Edges since the last strobe rise, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sinceRise <= 4'hf;
    end else if ($rose(sampleStrobe)) begin
      sinceRise <= 4'h1;
    end else if (sinceRise != 4'hf) begin
      sinceRise <= sinceRise + 4'h1;
    end
  end

  // Time stamp of the last accepted beat
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lastTs  <= '0;
      seenOne <= 1'b0;
    end else if (evtValid && evtReady) begin
      lastTs  <= evtData.timeStamp;
      seenOne <= 1'b1;
    end
  end

  sequence beatTaken;
    evtValid && evtReady;
  endsequence
  sequence beatWaits;
    evtValid && !evtReady;
  endsequence

  chk_rd_idle: assert property (
    !$past(regRd) || $past(regAddr) == 8'h3c |-> regRdData == 32'h0)
    else $error("read data outside read slot");
  chk_reset_quiet: assert property (
    $fell(rst) |-> !evtValid && regRdData == 32'h0)
    else $error("output after reset");
  chk_valid_hold: assert property (
    beatWaits |=> evtValid && $stable(evtData))
    else $error("beat not held");
  chk_beat_single: assert property (
    beatTaken |=> !evtValid)
    else $error("second beat straight after accept");
  chk_height_scale: assert property (
    evtValid |-> evtData.chan[0].height[3:0] == 4'h0
      && evtData.chan[15].height[3:0] == 4'h0)
    else $error("height scale");
  chk_width_zero: assert property (
    evtValid && evtData.chan[2].height == '0 |-> evtData.chan[2].width == '0)
    else $error("width with zero height");
  chk_valid_tick: assert property (
    $rose(evtValid) |-> sinceRise inside {[2:7]})
    else $error("beat not tied to a sample");
  chk_time_rises: assert property (
    $rose(evtValid) && seenOne |-> evtData.timeStamp > lastTs)
    else $error("time stamp not rising");
  cover_beat: cover property (beatWaits ##1 beatTaken);
endmodule : ppx_props

bind pulse_parameter_extractor ppx_props u_props (
  .clk(clk), .rst(rst), .sampleStrobe(sampleStrobe), .regAddr(regAddr),
  .regRd(regRd), .regRdData(regRdData), .evtValid(evtValid),
  .evtReady(evtReady), .evtData(evtData)
);

// ===== pulse_parameter_extractor.sv
// Pulse parameter extractor: thresholds, windows, area/height/width,
// abort handling and event hand-off over a valid/ready beat.
// Assumes converter strobe and words arrive from outside this clock.
//
// Function
// [RL1] Take a 14-bit sample from every channel on each 10 MHz strobe.
// [RL2] Area sums every sample inside the window, 18-bit full scale.
// [RL3] Height is the largest sample seen during the window.
// [RL4] Width is scaled area divided by height, times 64K.
// [RL5] Height is multiplied by 16 onto the 18-bit area scale.
// [RL6] Per-channel numeric thresholds combined with AND or OR.
// [RL7] Only events exceeding the threshold level are analysed.
// [RL8] Window runs from threshold crossing plus configured extension.
// [RL9] Area is multiplied by a programmable area scaling factor.
// [RL10] A new event inside an open extended window aborts both.
// [RL11] Electronic aborts are counted and readable.
// [RL12] Aborted events never reach the output or compensation.
// [RL13] Events are aborted when the output path is still busy.
// [RL14] Busy aborts capped at half the events, except in purity sorting.
// [RL15] Area, height and width are extracted for 16 channels.
// [RL16] Each event carries a time stamp parameter.
// [RL17] Data leave uncompensated; settings may change during acquisition.
// [RL18] A ratio between any two parameters is computed arithmetically.
// [RL19] Window closes after trigger falls and extension ends; one beat out.
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps

module pulse_parameter_extractor
  import ppx_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              clkEn,
  // Converter side
  input  wire logic                              sampleStrobe,
  input  wire logic [NUM_CHAN-1:0][SAMPLE_W-1:0] sampleData,
  // Register port
  input  wire logic [ADDR_W-1:0]                 regAddr,
  input  wire logic [DATA_W-1:0]                 regWrData,
  input  wire logic                              regWr,
  input  wire logic                              regRd,
  output logic      [DATA_W-1:0]                 regRdData,
  // Event output
  output logic                                   evtValid,
  input  wire logic                              evtReady,
  output event_t                                 evtData
);

  // Saturating divide, shared by width and ratio
  function automatic logic [PARAM_W-1:0] divSat(
    input logic [47:0]        dividend,
    input logic [PARAM_W-1:0] divisor
  );
    logic [47:0] quot;
    quot = 48'h0;
    if (divisor == '0) begin
      return '0;
    end
    quot = dividend / {30'h0, divisor};
    if (quot > {30'h0, PARAM_MAX}) begin
      return PARAM_MAX;
    end
    return quot[PARAM_W-1:0];
  endfunction : divSat

  // Registers seen by software
  logic [2:0]                       ctrl_reg;
  logic [15:0]                      chanEn_reg;
  logic [15:0]                      winExt_reg;
  logic [15:0]                      areaScale_reg;
  logic [2*SEL_W-1:0]               ratioSel_reg;
  logic [NUM_CHAN-1:0][SAMPLE_W-1:0] thr_reg;
  logic [31:0]                      abortCnt_reg;
  logic [31:0]                      eventCnt_reg;
  logic [31:0]                      ignoredCnt_reg;

  // Synchronisers
  logic                              strobeMeta;
  logic                              strobeSync;
  logic                              strobePrev;
  logic [NUM_CHAN-1:0][SAMPLE_W-1:0] dataMeta;
  logic [NUM_CHAN-1:0][SAMPLE_W-1:0] dataSync;

  // Window and accumulation
  win_state_t                        state_reg;
  logic [15:0]                       extCnt_reg;
  logic                              abortCur_reg;
  logic [NUM_CHAN-1:0][SUM_W-1:0]    sum_reg;
  logic [NUM_CHAN-1:0][SAMPLE_W-1:0] peak_reg;
  logic [TIME_W-1:0]                 timeNow_reg;
  logic [TIME_W-1:0]                 timeEvt_reg;
  logic                              trigPrev_reg;

  // Captured event awaiting scaling
  logic                              capValid_reg;
  logic [NUM_CHAN-1:0][SUM_W-1:0]    capSum_reg;
  logic [NUM_CHAN-1:0][SAMPLE_W-1:0] capPeak_reg;
  logic [TIME_W-1:0]                 capTime_reg;
  logic                              lastBusyAbort_reg;

  // Combinational helpers
  logic                              sampleTick;
  logic [NUM_CHAN-1:0]               over;
  logic                              trigger;
  logic                              trigRise;
  logic                              closeNow;
  logic                              collide;
  logic                              finish;
  logic                              finishAbort;
  logic                              outBusy;
  logic                              busyAbort;
  logic                              busyIgnore;
  chan_param_t [NUM_CHAN-1:0]        calc;
  logic [PARAM_W-1:0]                ratioNum;
  logic [PARAM_W-1:0]                ratioDen;

  // Second-stage flop feeds the edge detector, never the first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobeMeta <= 1'b0;
      strobeSync <= 1'b0;
      strobePrev <= 1'b0;
      dataMeta   <= '0;
      dataSync   <= '0;
    end else if (clkEn) begin
      strobeMeta <= sampleStrobe;
      strobeSync <= strobeMeta;
      strobePrev <= strobeSync;
      dataMeta   <= sampleData;
      dataSync   <= dataMeta;
    end
  end

  assign sampleTick = strobeSync & ~strobePrev; // RL1

  // Trigger qualification
  always_comb begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      over[c] = dataSync[c] > thr_reg[c]; // RL7
    end
  end

  // Disabled channels are neutral for both AND and OR
  always_comb begin
    if (chanEn_reg == '0) begin
      trigger = 1'b0;
    end else if (ctrl_reg[CTRL_AND]) begin
      trigger = &(over | ~chanEn_reg); // RL6
    end else begin
      trigger = |(over & chanEn_reg); // RL6
    end
  end

  assign trigRise = sampleTick & trigger & ~trigPrev_reg;
  assign collide  = (state_reg == ST_EXTEND) & trigRise; // RL10
  assign closeNow = (state_reg == ST_EXTEND) & sampleTick & ~trigger
                  & (extCnt_reg == '0); // RL19
  assign finish   = collide | closeNow;
  assign finishAbort = collide | abortCur_reg;

  // Output path busy when a scaled beat or a captured one is waiting
  assign outBusy    = capValid_reg | (evtValid & ~evtReady); // RL13
  assign busyAbort  = finish & ~finishAbort & outBusy
                    & (ctrl_reg[CTRL_PURITY] | ~lastBusyAbort_reg); // RL14
  assign busyIgnore = finish & ~finishAbort & outBusy
                    & ~ctrl_reg[CTRL_PURITY] & lastBusyAbort_reg; // RL14

  // Sample time base
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timeNow_reg  <= '0;
      trigPrev_reg <= 1'b0;
    end else if (clkEn && sampleTick) begin
      timeNow_reg  <= timeNow_reg + 32'h1;
      trigPrev_reg <= trigger;
    end
  end

  // Window state machine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg    <= ST_IDLE;
      extCnt_reg   <= '0;
      abortCur_reg <= 1'b0;
      timeEvt_reg  <= '0;
    end else if (clkEn && sampleTick) begin
      case (state_reg)
        ST_IDLE: begin
          if (ctrl_reg[CTRL_ENABLE] && trigger) begin
            state_reg    <= ST_OPEN; // RL8
            abortCur_reg <= 1'b0;
            timeEvt_reg  <= timeNow_reg; // RL16
          end
        end
        ST_OPEN: begin
          if (!trigger) begin
            state_reg  <= ST_EXTEND;
            extCnt_reg <= winExt_reg; // RL8
          end
        end
        ST_EXTEND: begin
          if (collide) begin
            // The newcomer shares signal with the old one
            state_reg    <= ST_OPEN; // RL10
            abortCur_reg <= 1'b1; // RL10
            timeEvt_reg  <= timeNow_reg;
          end else if (trigger) begin
            state_reg <= ST_OPEN;
          end else if (extCnt_reg == '0) begin
            state_reg <= ST_IDLE; // RL19
          end else begin
            extCnt_reg <= extCnt_reg - 16'h1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Area and height accumulation, restarted by a new window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sum_reg  <= '0;
      peak_reg <= '0;
    end else if (clkEn && sampleTick) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        if (state_reg == ST_IDLE || collide) begin
          sum_reg[c]  <= {18'h0, dataSync[c]};
          peak_reg[c] <= dataSync[c];
        end else begin
          sum_reg[c] <= sum_reg[c] + {18'h0, dataSync[c]}; // RL2
          if (dataSync[c] > peak_reg[c]) begin
            peak_reg[c] <= dataSync[c]; // RL3
          end
        end
      end
    end
  end

  // Capture a surviving event; the closing sample is not in the sum
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capValid_reg      <= 1'b0;
      capSum_reg        <= '0;
      capPeak_reg       <= '0;
      capTime_reg       <= '0;
      lastBusyAbort_reg <= 1'b0;
    end else if (clkEn) begin
      if (capValid_reg && !(evtValid && !evtReady)) begin
        capValid_reg <= 1'b0;
      end
      if (clkEn && sampleTick && finish) begin
        if (!finishAbort && !outBusy) begin
          capValid_reg <= 1'b1; // RL12
          capSum_reg   <= sum_reg;
          capPeak_reg  <= peak_reg;
          capTime_reg  <= timeEvt_reg;
        end
        if (!finishAbort) begin
          lastBusyAbort_reg <= busyAbort; // RL14
        end
      end
    end
  end

  // Scaling of captured values
  always_comb begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      logic [47:0] scaled;
      scaled = {16'h0, capSum_reg[c]} * {32'h0, areaScale_reg}; // RL9
      scaled = scaled >> AREA_FRAC;
      if (scaled > {30'h0, PARAM_MAX}) begin
        calc[c].area = PARAM_MAX;
      end else begin
        calc[c].area = scaled[PARAM_W-1:0]; // RL2
      end
      calc[c].height = {capPeak_reg[c], 4'h0}; // RL5
      calc[c].width  = divSat({14'h0, calc[c].area, 16'h0},
                              calc[c].height); // RL4
    end
  end

  // Parameter selector for the ratio: channel times three plus kind
  function automatic logic [PARAM_W-1:0] pickParam(
    input chan_param_t [NUM_CHAN-1:0] p,
    input logic [SEL_W-1:0]           sel
  );
    logic [4:0] chIdx;
    chIdx = 5'(sel / 6'd3);
    if (chIdx >= 5'(NUM_CHAN)) begin
      return '0;
    end
    case (sel % 6'd3)
      6'd0:    return p[chIdx[3:0]].area;
      6'd1:    return p[chIdx[3:0]].height;
      default: return p[chIdx[3:0]].width;
    endcase
  endfunction : pickParam

  assign ratioNum = pickParam(calc, ratioSel_reg[SEL_W-1:0]); // RL18
  assign ratioDen = pickParam(calc, ratioSel_reg[2*SEL_W-1:SEL_W]);

  // One beat per surviving event
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evtValid <= 1'b0;
      evtData  <= '0;
    end else if (clkEn) begin
      if (capValid_reg && !(evtValid && !evtReady)) begin
        evtValid          <= 1'b1; // RL19
        evtData.chan      <= calc; // RL15
        evtData.timeStamp <= capTime_reg; // RL16
        evtData.ratio     <= divSat({22'h0, ratioNum, 8'h0},
                                    ratioDen); // RL18
      end else if (evtReady) begin
        evtValid <= 1'b0;
      end
    end
  end

  // Abort, event and ignore counters; hardware increments win over clears
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      abortCnt_reg   <= '0;
      eventCnt_reg   <= '0;
      ignoredCnt_reg <= '0;
    end else if (clkEn) begin
      if (sampleTick && finish && (finishAbort || busyAbort)) begin
        abortCnt_reg <= abortCnt_reg + 32'h1; // RL11
      end else if (regWr && regAddr == ADDR_ABORTS) begin
        abortCnt_reg <= '0;
      end
      if (sampleTick && finish) begin
        eventCnt_reg <= eventCnt_reg + 32'h1;
      end else if (regWr && regAddr == ADDR_EVENTS) begin
        eventCnt_reg <= '0;
      end
      if (sampleTick && busyIgnore) begin
        ignoredCnt_reg <= ignoredCnt_reg + 32'h1; // RL14
      end else if (regWr && regAddr == ADDR_IGNORED) begin
        ignoredCnt_reg <= '0;
      end
    end
  end

  // Settings writes take effect at once, even mid acquisition
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg      <= CTRL_RST;
      chanEn_reg    <= CHAN_EN_RST;
      winExt_reg    <= WIN_EXT_RST;
      areaScale_reg <= AREA_SCL_RST;
      ratioSel_reg  <= RATIO_SEL_RST;
      thr_reg       <= {NUM_CHAN{THR_RST}};
    end else if (clkEn && regWr) begin
      case (regAddr)
        ADDR_CTRL:      ctrl_reg      <= regWrData[2:0];
        ADDR_CHAN_EN:   chanEn_reg    <= regWrData[15:0];
        ADDR_WIN_EXT:   winExt_reg    <= regWrData[15:0]; // RL17
        ADDR_AREA_SCL:  areaScale_reg <= regWrData[15:0]; // RL9
        ADDR_RATIO_SEL: ratioSel_reg  <= {regWrData[13:8],
                                          regWrData[5:0]};
        default: begin
          if (regAddr[7:6] == ADDR_THR_BASE[7:6]) begin
            thr_reg[regAddr[5:2]] <= regWrData[SAMPLE_W-1:0]; // RL6
          end
        end
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData <= '0;
    end else if (clkEn) begin
      regRdData <= '0;
      if (regRd) begin
        case (regAddr)
          ADDR_CTRL:      regRdData <= {29'h0, ctrl_reg};
          ADDR_CHAN_EN:   regRdData <= {16'h0, chanEn_reg};
          ADDR_WIN_EXT:   regRdData <= {16'h0, winExt_reg};
          ADDR_AREA_SCL:  regRdData <= {16'h0, areaScale_reg};
          ADDR_RATIO_SEL: regRdData <= {18'h0, ratioSel_reg[11:6],
                                        2'h0, ratioSel_reg[5:0]};
          ADDR_ABORTS:    regRdData <= abortCnt_reg; // RL11
          ADDR_EVENTS:    regRdData <= eventCnt_reg;
          ADDR_IGNORED:   regRdData <= ignoredCnt_reg;
          ADDR_STATUS:    regRdData <= {28'h0, lastBusyAbort_reg,
                                        outBusy, state_reg};
          default: begin
            if (regAddr[7:6] == ADDR_THR_BASE[7:6]) begin
              regRdData <= {18'h0, thr_reg[regAddr[5:2]]};
            end
          end
        endcase
      end
    end
  end

endmodule : pulse_parameter_extractor

// ===== testbench.sv
// Testbench: register tasks, pulse shapes and event beat checks.
// Assumes the converter model and checker bound to the design.
`timescale 1ns/1ps

module testbench
  import ppx_pkg::*;
;
  logic                              clk;
  logic                              rst;
  logic                              sampleStrobe;
  logic                              regWr;
  logic                              regRd;
  logic                              evtValid;
  logic                              evtReady;
  logic [NUM_CHAN-1:0][SAMPLE_W-1:0] sampleData;
  logic [NUM_CHAN-1:0][SAMPLE_W-1:0] level;
  logic [ADDR_W-1:0]                 regAddr;
  logic [DATA_W-1:0]                 regWrData;
  logic [DATA_W-1:0]                 regRdData;
  event_t                            evtData;
  event_t                            beats[$];
  int                                n_fail;
  int                                n_compared;
  logic [PARAM_W-1:0]                ratioExp = 18'h00100;
  logic [ADDR_W-1:0] rAddr [10] = '{ADDR_CTRL, ADDR_CHAN_EN, ADDR_WIN_EXT,
    ADDR_AREA_SCL, ADDR_THR_BASE, ADDR_ABORTS, 8'h3c, ADDR_RATIO_SEL,
    ADDR_EVENTS, ADDR_STATUS};
  logic [DATA_W-1:0] rVal [10] = '{32'h0, 32'h1, 32'h0, 32'h100, 32'h100,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  adc_model adc (.clk(clk), .rst(rst), .level(level),
    .sampleStrobe(sampleStrobe), .sampleData(sampleData));
  pulse_parameter_extractor dut (.clk(clk), .rst(rst), .clkEn(1'b1),
    .sampleStrobe(sampleStrobe), .sampleData(sampleData), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .evtValid(evtValid), .evtReady(evtReady),
    .evtData(evtData));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (evtValid === 1'b1 && evtReady === 1'b1) begin
      beats.push_back(evtData);
    end
  end

  task automatic finish_test;
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge clk);
    regWr     <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    #1 cmp(regRdData, e);
  endtask : rd

  task automatic put(input logic [SAMPLE_W-1:0] a,
                     input logic [SAMPLE_W-1:0] b);
    @(posedge clk);
    level[0] <= a;
    level[1] <= b;
    repeat (9) @(posedge clk);
  endtask : put

  // Peak 0x400, sum 0x900; other channel stays at baseline unless both
  task automatic shape(input logic both);
    put(14'h0200, both ? 14'h0200 : 14'h0010);
    put(14'h0400, both ? 14'h0400 : 14'h0010);
    put(14'h0300, both ? 14'h0300 : 14'h0010);
  endtask : shape

  task automatic rest(input int n);
    repeat (n) put(14'h0010, 14'h0010);
  endtask : rest

  function automatic logic [PARAM_W-1:0] wexp(input logic [PARAM_W-1:0] a,
                                               input logic [PARAM_W-1:0] h);
    logic [47:0] q;
    q = ({30'h0, a} << 16) / {30'h0, h};
    return (q > 48'h3ffff) ? PARAM_MAX : q[PARAM_W-1:0];
  endfunction : wexp

  task automatic expect_evt(input logic [PARAM_W-1:0] a);
    event_t e;
    repeat (300) if (beats.size() == 0) @(posedge clk);
    cmp(32'(beats.size()), 32'h1);
    if (beats.size() != 0) begin
      e = beats.pop_front();
      cmp(32'(e.chan[0].area), 32'(a));
      cmp(32'(e.chan[0].height), 32'h4000);
      cmp(32'(e.chan[0].width), 32'(wexp(a, 18'h04000)));
      cmp(32'(e.ratio), 32'(ratioExp));
    end
  endtask : expect_evt

  task automatic expect_none;
    repeat (100) @(posedge clk);
    cmp(32'(beats.size()), 32'h0);
  endtask : expect_none

  // Output stalled over three events, then drained
  task automatic busy_run(input logic [2:0] c, input int ab, input int ig);
    wr(ADDR_CTRL, {29'h0, c});
    wr(ADDR_ABORTS, 32'h0);
    wr(ADDR_IGNORED, 32'h0);
    @(posedge clk) evtReady <= 1'b0;
    repeat (3) begin
      shape(1'b0);
      rest(6);
    end
    rd(ADDR_ABORTS, 32'(ab));
    rd(ADDR_IGNORED, 32'(ig));
    rd(ADDR_STATUS, {28'h0, c[2], 3'h4});
    @(posedge clk) evtReady <= 1'b1;
    expect_evt(18'h00910);
    expect_none();
  endtask : busy_run

  initial begin
    rst       = 1'b1;
    regWr     = 1'b0;
    regRd     = 1'b0;
    regAddr   = '0;
    regWrData = '0;
    evtReady  = 1'b1;
    // Channel 2 dark, so a zero height reaches the width check
    level     = {{13{14'h0010}}, 14'h0000, 14'h0010, 14'h0010};
    n_fail    = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) rd(rAddr[i], rVal[i]);
    shape(1'b0);
    rest(6);
    expect_none();
    wr(ADDR_CTRL, 32'h1);
    put(THR_RST, THR_RST);
    rest(6);
    expect_none();
    shape(1'b0);
    rest(6);
    expect_evt(18'h00910);
    wr(ADDR_WIN_EXT, 32'h2);
    wr(ADDR_AREA_SCL, 32'h80);
    shape(1'b0);
    rest(6);
    expect_evt(18'h00498);
    wr(ADDR_WIN_EXT, 32'h3);
    shape(1'b0);
    rest(1);
    shape(1'b0);
    rest(8);
    expect_none();
    rd(ADDR_ABORTS, 32'h2);
    wr(ADDR_WIN_EXT, 32'h0);
    wr(ADDR_AREA_SCL, 32'h100);
    wr(ADDR_CHAN_EN, 32'h3);
    wr(ADDR_CTRL, 32'h3);
    shape(1'b0);
    rest(6);
    expect_none();
    shape(1'b1);
    rest(6);
    expect_evt(18'h00910);
    wr(ADDR_CHAN_EN, 32'h1);
    busy_run(3'h1, 1, 1);
    busy_run(3'h5, 2, 0);
    // Height over area of channel 0
    ratioExp = 18'(32'h400000 / 32'h910);
    wr(ADDR_RATIO_SEL, 32'h1);
    shape(1'b0);
    rest(6);
    expect_evt(18'h00910);
    rd(ADDR_EVENTS, 32'hc);
    finish_test();
  end

  // About 2,000 cycles of tests; fifteen times that is a hang
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    finish_test();
  end
endmodule : testbench
